// [dv/cell_model.sv]
// neighbouring logic cells driving the block's local literals and clock lines
module cell_model
	import pterm_pkg::*;
(
	input  logic               core_clk, // system clock
	input  logic [NUM_LIT-1:0] want,     // literal values to present
	input  logic [NUM_CLK-1:0] level,    // requested clock line levels
	output logic [NUM_LIT-1:0] lits,     // local literals
	output logic [NUM_CLK-1:0] clk_out   // local clock lines
);
	timeunit 1ns;
	timeprecision 1ns;
	// registered like a real cell output; clock lines stay low outside pulses
	always @(posedge core_clk) begin
		lits    <= want;
		clk_out <= level;
	end
endmodule : cell_model

// [dv/testbench.sv]
// self-checking bench for the product-term block
module testbench
	import pterm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic               core_clk = 1'b0;
	logic               rst_n    = 1'b0;
	blk_cfg_type        blk_cfg;
	mc_cfg_type         mc_cfg [NUM_MC];
	ctrl_in_type        pins;
	logic [NUM_LIT-1:0] want     = '0;
	logic [NUM_LIT-1:0] lits;
	logic [NUM_CLK-1:0] level    = '0;
	logic [NUM_CLK-1:0] clk_local;
	logic               dclr_n   = 1'b1;
	logic [NUM_MC-1:0]  mc_out;
	logic [NUM_FB-1:0]  fb_out;
	logic [NUM_MC-1:0]  q        = '0;
	logic [6:0]         e;
	int                 fails    = 0;
	int                 n_checks = 0;

	always #25 core_clk = ~core_clk;

	cell_model u_cell_model (.core_clk(core_clk), .want(want), .level(level), .lits(lits),
		.clk_out(clk_local));
	pterm_block u_pterm_block (.core_clk(core_clk), .rst_n(rst_n), .blk_cfg(blk_cfg),
		.mc_cfg(mc_cfg), .lits(lits), .device_wide_clear_n(dclr_n), .mc_out(mc_out),
		.ctrl({pins.dedicated_clk, pins.global_sig, clk_local, pins.clk_en, pins.clr_local}),
		.fb_out(fb_out));

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
		@(negedge core_clk);
		n_checks++;
		if ((got & m) !== (exp & m)) begin
			fails++;
			$display("BAD %0t outputs %h expected %h", $time, got & m, exp & m);
		end
	endtask : cmp

	task automatic set_lits(input logic [31:0] v);
		@(posedge core_clk);
		want <= v;
		repeat (2) @(posedge core_clk);
	endtask : set_lits

	// pin and global sources pass a two-stage synchroniser, so allow five edges
	task automatic clk_line(input int k, input int src, input logic lvl);
		@(posedge core_clk);
		if (src == 0) level[k] <= lvl;
		else if (src == 1) pins.dedicated_clk[k] <= lvl;
		else pins.global_sig[k] <= lvl;
		repeat (5) @(posedge core_clk);
	endtask : clk_line

	// pulse block clock 0 and update the expected register states
	task automatic tick0(input int src, input logic [2:0] v, input logic en);
		clk_line(0, src, 1'b1);
		clk_line(0, src, 1'b0);
		if (en) begin
			q[13] = q[13] ^ v[0];
			q[12] = v[0];
			q[14] = (v[1] & v[2]) ? ~q[14] : v[1] ? 1'b1 : v[2] ? 1'b0 : q[14];
			q[15] = v[1] ? 1'b1 : v[2] ? 1'b0 : q[15];
		end
	endtask : tick0

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	initial begin
		blk_cfg = '{clk_src: '{SRC_LOCAL, SRC_LOCAL}, clk_fall: 2'b10, clr_from_local: 2'b11,
			clr_inv: 2'b10, dev_clr_en: 1'b1};
		pins = '{dedicated_clk: 2'b00, global_sig: 2'b00, clk_local: 2'b00, clk_en: 2'b11,
			clr_local: 2'b10};
		for (int m = 0; m < NUM_MC; m++) begin
			mc_cfg[m] = '0;
			mc_cfg[m].kind = REG_D;
			mc_cfg[m].clr_sel = CLR_NONE;
			mc_cfg[m].comb = 1'b1;
		end
		mc_cfg[0].use_true = {41'h4, 41'h1};
		mc_cfg[0].use_comp[0] = 41'h2;
		mc_cfg[1].use_true = {41'h10, 41'h8};
		mc_cfg[1].inv_pt = 1'b1;
		mc_cfg[2].use_true = {41'h20, 41'h20};
		mc_cfg[2].xor_out = 1'b1;
		mc_cfg[3].use_true = {41'h100, 41'h80};
		mc_cfg[3].lend = 2'b11;
		mc_cfg[4].use_true = {41'h400, 41'h200};
		mc_cfg[4].lend = 2'b11;
		mc_cfg[4].pass_exp = 1'b1;
		mc_cfg[5].use_true = {41'h800, 41'h800};
		mc_cfg[5].take_exp = 1'b1;
		mc_cfg[6].use_true = {41'h1_0000_0000, 41'h1_0000_0000};
		for (int m = 11; m < NUM_MC; m++) begin
			mc_cfg[m].comb = 1'b0;
			mc_cfg[m].use_true = {41'h1000, 41'h1000};
		end
		mc_cfg[14].use_true = {41'h4000, 41'h2000};
		mc_cfg[15].use_true = {41'h4000, 41'h2000};
		mc_cfg[13].kind = REG_T;
		mc_cfg[14].kind = REG_JK;
		mc_cfg[15].kind = REG_SR;
		mc_cfg[11].clk_sel = 1'b1;
		mc_cfg[11].clr_sel = CLR_B;
		mc_cfg[12].clr_sel = CLR_A;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		cmp(mc_out, 16'h0000, 16'hF800);
		for (int i = 0; i < 64; i++) begin
			set_lits(i * 32'h0000_0F3B);
			e[0] = (lits[0] & ~lits[1]) | lits[2];
			e[1] = lits[3] | ~lits[4];
			e[2] = ~lits[5];
			e[4:3] = 2'b00;
			e[5] = |lits[11:7];
			e[6] = e[0];
			cmp(mc_out, {5'h00, 4'hF, e}, 16'h07FF);
			cmp({7'h0, fb_out}, {7'h00, 2'h3, e}, 16'h01FF);
		end
		for (int i = 0; i < 8; i++) begin
			set_lits({17'h0, i[2:0], 12'h0});
			tick0(0, i[2:0], 1'b1);
			cmp(mc_out, q, 16'hF800);
		end
		@(posedge core_clk);
		pins.clk_en[0] <= 1'b0;
		set_lits(32'h0000_7000);
		tick0(0, 3'b111, 1'b0);
		cmp(mc_out, q, 16'hF800);
		@(posedge core_clk);
		pins.clk_en[0] <= 1'b1;
		clk_line(1, 0, 1'b1);
		cmp(mc_out, q, 16'h0800);
		clk_line(1, 0, 1'b0);
		q[11] = 1'b1;
		cmp(mc_out, q, 16'h0800);
		for (int s = 1; s < 3; s++) begin
			@(posedge core_clk);
			blk_cfg.clk_src[0] <= (s == 1) ? SRC_PIN : SRC_GLOBAL;
			set_lits({17'h0, 2'b00, ~q[12], 12'h0});
			tick0(s, {2'b00, ~q[12]}, 1'b1);
			cmp(mc_out, q, 16'hF800);
		end
		@(posedge core_clk);
		blk_cfg.clk_src[0] <= SRC_LOCAL;
		set_lits(32'h0000_1000);
		tick0(0, 3'b001, 1'b1);
		@(posedge core_clk);
		pins.clr_local[0] <= 1'b1;
		tick0(0, 3'b001, 1'b1);
		q[12] = 1'b0;
		cmp(mc_out, q, 16'hF800);
		@(posedge core_clk);
		pins.clr_local <= 2'b00;
		repeat (3) @(posedge core_clk);
		q[11] = 1'b0;
		cmp(mc_out, q, 16'hF800);
		@(posedge core_clk);
		pins.clr_local[1] <= 1'b1;
		blk_cfg.clr_from_local[0] <= 1'b0;
		tick0(0, 3'b001, 1'b1);
		cmp(mc_out, q, 16'hF800);
		@(posedge core_clk);
		pins.global_sig[0] <= 1'b1;
		repeat (4) @(posedge core_clk);
		q[12] = 1'b0;
		cmp(mc_out, q, 16'hF800);
		@(posedge core_clk);
		dclr_n <= 1'b0;
		tick0(0, 3'b011, 1'b0);
		q[15:11] = 5'h00;
		cmp(mc_out, q, 16'hF800);
		@(posedge core_clk);
		dclr_n <= 1'b1;
		repeat (5) @(posedge core_clk);
		end_of_test();
	end
endmodule : testbench

// [hdl/pterm_block.sv]
// product-term block: sixteen macrocells, block clocks, clears and feedback
// Behaviour
// RL1 - sixteen macrocells, each two product terms into OR/XOR and a register
// RL2 - thirty-two local literals feed every product term
// RL3 - nine macrocell outputs feed back as product-term literals; a bypassed one feeds back 0 to itself and to lower macrocells
// RL4 - each macrocell combinatorial (register bypassed) or registered
// RL5 - each term feeds its own OR gate or leaves as an expander
// RL6 - one product term per macrocell has a selectable inversion
// RL7 - each register works as D, T, JK or SR
// RL8 - each register picks one of two block clocks
// RL9 - each block clock comes from a pin, global or local line
// RL10 - each block clock has its own enable, applied with it
// RL11 - the two block clocks may serve opposite edges
// RL12 - two block clears; each register picks one or none
// RL13 - each block clear has a selectable inversion
// RL14 - a macrocell sum may take up to thirty-two terms
// RL15 - expanders chain through up to fifteen sets of two
// RL16 - enabled chip-wide clear resets every register, above everything else
// RL17 - a lent term no longer feeds its own macrocell
module pterm_block
	import pterm_pkg::*;
#(
	parameter int MC_COUNT = NUM_MC, // macrocells
	parameter int FB_COUNT = NUM_FB  // fed-back macrocells
) (
	input  logic                 core_clk,            // system clock
	input  logic                 rst_n,               // async reset, active low
	input  blk_cfg_type          blk_cfg,             // block-wide configuration
	input  mc_cfg_type           mc_cfg [MC_COUNT],   // per-macrocell configuration
	input  logic [NUM_LIT-1:0]   lits,                // local literals
	input  ctrl_in_type          ctrl,                // clock, enable, clear lines
	input  logic                 device_wide_clear_n, // chip-wide clear pin
	output logic [MC_COUNT-1:0]  mc_out,              // macrocell outputs
	output logic [FB_COUNT-1:0]  fb_out               // lines fed back locally
);

	if (MC_COUNT != NUM_MC || FB_COUNT > MC_COUNT || FB_COUNT != NUM_FB) begin : g_bad
		$error("pterm_block: counts do not match the literal array");
	end
	if (MC_COUNT - 1 > 2 * MAX_SETS) begin : g_deep
		$error("pterm_block: expander chain longer than the sets allow");
	end

	// pins and globals are outside this clock; the edge detectors read stage two
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	logic [NUM_CLK-1:0] pin_s;
	logic [NUM_CLK-1:0] glob_s;
	logic               devclr_s;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
		end else begin
			sync1_reg <= {device_wide_clear_n, ctrl.global_sig, ctrl.dedicated_clk};
			sync2_reg <= sync1_reg;
		end
	end

	assign pin_s    = sync2_reg[NUM_CLK-1:0];
	assign glob_s   = sync2_reg[2*NUM_CLK-1:NUM_CLK];
	assign devclr_s = sync2_reg[2*NUM_CLK];

	logic dev_clr;
	assign dev_clr = blk_cfg.dev_clr_en & ~devclr_s; // RL16

	// block clocks become one-cycle ticks; skip the cycle after reset so a
	// source already high is not mistaken for an edge
	logic                armed_reg;
	logic [NUM_CLK-1:0]  src_lvl;
	logic [NUM_CLK-1:0]  prev_reg;
	logic [NUM_CLK-1:0]  edge_seen;
	logic [NUM_CLK-1:0]  tick;
	logic [NUM_CLR-1:0]  clr_act;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			armed_reg <= 1'b0;
		end else begin
			armed_reg <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= '0;
		end else begin
			prev_reg <= src_lvl;
		end
	end

	for (genvar c = 0; c < NUM_CLK; c++) begin : g_clk
		always_comb begin
			unique case (blk_cfg.clk_src[c]) // RL9
				SRC_PIN:    src_lvl[c] = pin_s[c];
				SRC_GLOBAL: src_lvl[c] = glob_s[c];
				SRC_LOCAL:  src_lvl[c] = ctrl.clk_local[c];
				default:    src_lvl[c] = 1'b0;
			endcase
		end

		assign edge_seen[c] = blk_cfg.clk_fall[c] ? (prev_reg[c] & ~src_lvl[c]) // RL11
		                                          : (~prev_reg[c] & src_lvl[c]);
		assign tick[c] = armed_reg & edge_seen[c] & ctrl.clk_en[c]; // RL10

		sequence s_low_high;
			!src_lvl[c] ##1 src_lvl[c];
		endsequence
		sequence s_high_low;
			src_lvl[c] ##1 !src_lvl[c];
		endsequence

		// enable and arming are judged in the cycle that sees the new level
		a_rise_ticks: assert property (@(posedge core_clk) disable iff (!rst_n) // RL11
			s_low_high ##0 (armed_reg && !blk_cfg.clk_fall[c] && ctrl.clk_en[c])
			|-> tick[c])
			else $error("rising edge with enable gave no tick");
		a_fall_ticks: assert property (@(posedge core_clk) disable iff (!rst_n) // RL11
			s_high_low ##0 (armed_reg && blk_cfg.clk_fall[c] && ctrl.clk_en[c])
			|-> tick[c])
			else $error("falling edge with enable gave no tick");
		a_en_gates: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
			!ctrl.clk_en[c] |-> !tick[c])
			else $error("tick without its clock enable");
		a_armed_no_tick: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
			!armed_reg |-> !tick[c])
			else $error("tick in the first cycle after reset");
		a_tick_on_edge: assert property (@(posedge core_clk) disable iff (!rst_n) // RL11
			tick[c] |-> src_lvl[c] != $past(src_lvl[c])
				&& src_lvl[c] == !blk_cfg.clk_fall[c])
			else $error("tick without a matching source edge");
	end

	for (genvar k = 0; k < NUM_CLR; k++) begin : g_clr
		// polarity applies after the source pick
		assign clr_act[k] = (blk_cfg.clr_from_local[k] ? ctrl.clr_local[k] // RL12
		                                               : glob_s[k]) ^ blk_cfg.clr_inv[k]; // RL13
		a_clr_inverts: assert property (@(posedge core_clk) disable iff (!rst_n) // RL13
			blk_cfg.clr_from_local[k] && !ctrl.clr_local[k]
			|-> clr_act[k] == blk_cfg.clr_inv[k])
			else $error("clear polarity not applied");
	end

	// clear choice of one macrocell
	function automatic logic clr_pick(input clr_sel_type s,
	                                  input logic [NUM_CLR-1:0] a);
		unique case (s)
			CLR_A:   clr_pick = a[0];
			CLR_B:   clr_pick = a[1];
			default: clr_pick = 1'b0;
		endcase
	endfunction : clr_pick

	// expanders climb from lower to upper macrocells; feedback from the same
	// or a higher macrocell is taken from its register, which keeps the array
	// free of combinational loops; a bypassed cell's register never loads, so on such paths it feeds back 0
	logic [MC_COUNT:0]   exp_chain;
	logic [MC_COUNT-1:0] mc_q;
	logic [MC_COUNT-1:0] mc_tick;
	logic [MC_COUNT-1:0] mc_clr;

	assign exp_chain[0] = 1'b0;

	for (genvar m = 0; m < MC_COUNT; m++) begin : g_mc
		logic [NUM_IN-1:0] in_vec;

		assign in_vec[NUM_LIT-1:0] = lits; // RL2
		for (genvar f = 0; f < FB_COUNT; f++) begin : g_fb
			if (f < m) begin : g_live
				assign in_vec[NUM_LIT+f] = mc_out[f]; // RL3
			end else begin : g_held
				assign in_vec[NUM_LIT+f] = mc_q[f]; // RL3
			end
		end

		assign mc_tick[m] = tick[mc_cfg[m].clk_sel]; // RL8
		assign mc_clr[m]  = clr_pick(mc_cfg[m].clr_sel, clr_act); // RL12

		pterm_macrocell u_cell (
			.core_clk (core_clk),
			.rst_n    (rst_n),
			.cfg      (mc_cfg[m]),
			.lits     (in_vec),
			.exp_in   (exp_chain[m]),
			.tick     (mc_tick[m]),
			.clr      (mc_clr[m]),
			.dev_clr  (dev_clr),
			.exp_out  (exp_chain[m+1]), // RL15
			.mc_out   (mc_out[m]),
			.mc_q     (mc_q[m])
		);

		a_clr_clears: assert property (@(posedge core_clk) disable iff (!rst_n) // RL12
			mc_clr[m] |=> mc_q[m] == REG_RESET)
			else $error("selected clear did not clear register");
		a_clk_route: assert property (@(posedge core_clk) disable iff (!rst_n) // RL8
			mc_tick[m] |-> tick[mc_cfg[m].clk_sel] && ctrl.clk_en[mc_cfg[m].clk_sel])
			else $error("macrocell clocked from the wrong block clock");
		// a bypassed cell that takes a live expander must show it at once
		a_exp_reaches: assert property (@(posedge core_clk) disable iff (!rst_n) // RL14
			mc_cfg[m].comb && mc_cfg[m].take_exp && !mc_cfg[m].xor_out && exp_chain[m]
			|-> mc_out[m])
			else $error("taken expander missing from the sum");
	end

	assign fb_out = mc_out[FB_COUNT-1:0]; // RL3

	// the pin must sit at one level through both stages before it counts
	sequence s_pin_held_low;
		(blk_cfg.dev_clr_en && !device_wide_clear_n)[*3];
	endsequence
	sequence s_pin_held_high;
		device_wide_clear_n[*3];
	endsequence

	a_dev_clr_sync: assert property (@(posedge core_clk) disable iff (!rst_n) // RL16
		s_pin_held_low |-> dev_clr)
		else $error("chip-wide clear not seen after two stages");
	a_dev_clr_idle: assert property (@(posedge core_clk) disable iff (!rst_n) // RL16
		s_pin_held_high |-> !dev_clr)
		else $error("chip-wide clear acted with the pin high");
	a_dev_clr_all: assert property (@(posedge core_clk) disable iff (!rst_n) // RL16
		dev_clr |=> mc_q == '0)
		else $error("chip-wide clear left a register set");
	a_dev_clr_off: assert property (@(posedge core_clk) disable iff (!rst_n) // RL16
		!blk_cfg.dev_clr_en |-> !dev_clr)
		else $error("chip-wide clear acted while disabled");

endmodule : pterm_block

// [hdl/pterm_macrocell.sv]
// one macrocell: two product terms, expander steering, sum and register
module pterm_macrocell
	import pterm_pkg::*;
(
	input  logic              core_clk, // system clock
	input  logic              rst_n,    // async reset, active low
	input  mc_cfg_type        cfg,      // static configuration
	input  logic [NUM_IN-1:0] lits,     // literals plus feedback
	input  logic              exp_in,   // expanders from lower neighbour
	input  logic              tick,     // selected clock edge with enable
	input  logic              clr,      // selected block clear
	input  logic              dev_clr,  // chip-wide clear
	output logic              exp_out,  // expanders toward upper neighbour
	output logic              mc_out,   // macrocell output
	output logic              mc_q      // register state
);

	// an empty term (no literal chosen) is a constant one
	function automatic logic pterm(input logic [NUM_IN-1:0] t,
	                               input logic [NUM_IN-1:0] c,
	                               input logic [NUM_IN-1:0] l);
		pterm = (&(~t | l)) & (&(~c | ~l));
	endfunction : pterm

	logic [NUM_PT-1:0] pt;
	logic [NUM_PT-1:0] prim;
	logic              exp_used;
	logic              sum;
	logic              logic_res;
	logic              q_reg;
	logic              q_next;

	assign pt[0] = pterm(cfg.use_true[0], cfg.use_comp[0], lits);        // RL1
	assign pt[1] = pterm(cfg.use_true[1], cfg.use_comp[1], lits) ^ cfg.inv_pt; // RL6
	assign prim = pt & ~cfg.lend;                                         // RL17
	assign exp_out = (|(pt & cfg.lend)) | (cfg.pass_exp & exp_in);        // RL5
	assign exp_used = cfg.take_exp & exp_in;                              // RL14
	assign sum = (|prim) | exp_used;
	assign logic_res = sum ^ cfg.xor_out;

	// jk and sr take term 1 as the reset side, the rest as set
	always_comb begin
		unique case (cfg.kind) // RL7
			REG_D:  q_next = logic_res;
			REG_T:  q_next = q_reg ^ logic_res;
			REG_JK: q_next = ((prim[0] | exp_used) & ~q_reg) | (~prim[1] & q_reg);
			REG_SR: q_next = (prim[0] | exp_used) | (q_reg & ~prim[1]);
			default: q_next = q_reg;
		endcase
	end

	// dev clear beats block clear beats capture
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q_reg <= REG_RESET;
		end else if (dev_clr) begin
			q_reg <= REG_RESET; // RL16
		end else if (clr) begin
			q_reg <= REG_RESET; // RL12
		end else if (tick && !cfg.comb) begin
			q_reg <= q_next;
		end
	end

	assign mc_q = q_reg;
	assign mc_out = cfg.comb ? logic_res : q_reg; // RL4

	a_dev_clr_first: assert property (@(posedge core_clk) disable iff (!rst_n) // RL16
		dev_clr |=> mc_q == REG_RESET)
		else $error("chip-wide clear did not clear register");
	a_hold_no_tick: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
		!tick && !clr && !dev_clr |=> $stable(mc_q))
		else $error("register moved without a clock tick");
	a_t_toggles: assert property (@(posedge core_clk) disable iff (!rst_n) // RL7
		tick && !clr && !dev_clr && !cfg.comb && cfg.kind == REG_T && logic_res
		|=> mc_q != $past(mc_q))
		else $error("t register failed to toggle");
	a_lent_gone: assert property (@(posedge core_clk) disable iff (!rst_n) // RL17
		cfg.lend == 2'h3 && !cfg.take_exp |-> logic_res == cfg.xor_out)
		else $error("lent term still reached own sum");
	a_comb_bypass: assert property (@(posedge core_clk) disable iff (!rst_n) // RL4
		cfg.comb |-> mc_out == logic_res)
		else $error("bypassed macrocell did not drive logic result");

endmodule : pterm_macrocell

// [hdl/pterm_pkg.sv]
// shared constants, configuration types and carriers for the macrocell array
package pterm_pkg;

	localparam int NUM_MC   = 16;  // macrocells per block
	localparam int NUM_LIT  = 32;  // general literals from local lines
	localparam int NUM_FB   = 9;   // macrocells fed back into the array
	localparam int NUM_IN   = NUM_LIT + NUM_FB;
	localparam int NUM_PT   = 2;   // product terms per macrocell
	localparam int NUM_CLK  = 2;   // block-wide clocks
	localparam int NUM_CLR  = 2;   // block-wide clears
	localparam int MAX_SETS = 15;  // expander sets a macrocell may collect
	localparam int SYNC_W   = 2 * NUM_CLK + 1;

	localparam logic REG_RESET = 1'b0;

	typedef enum logic [3:0] {
		REG_D  = 4'h1,
		REG_T  = 4'h2,
		REG_JK = 4'h4,
		REG_SR = 4'h8
	} reg_kind_type;

	typedef enum logic [2:0] {
		SRC_PIN    = 3'h1,
		SRC_GLOBAL = 3'h2,
		SRC_LOCAL  = 3'h4
	} clk_src_type;

	typedef enum logic [2:0] {
		CLR_NONE = 3'h1,
		CLR_A    = 3'h2,
		CLR_B    = 3'h4
	} clr_sel_type;

	typedef struct packed {
		logic [NUM_PT-1:0][NUM_IN-1:0] use_true;  // literal taken true
		logic [NUM_PT-1:0][NUM_IN-1:0] use_comp;  // literal taken inverted
		logic [NUM_PT-1:0]             lend;      // term lent as expander
		logic                          pass_exp;  // forward incoming expanders
		logic                          take_exp;  // OR incoming expanders here
		logic                          inv_pt;    // invert product term 1
		logic                          xor_out;   // xor polarity of the sum
		logic                          comb;      // bypass the register
		reg_kind_type                  kind;
		logic                          clk_sel;   // block clock 0 or 1
		clr_sel_type                   clr_sel;
	} mc_cfg_type;

	typedef struct packed {
		clk_src_type [NUM_CLK-1:0] clk_src;
		logic [NUM_CLK-1:0]        clk_fall;       // capture on falling edge
		logic [NUM_CLR-1:0]        clr_from_local; // clear from local line
		logic [NUM_CLR-1:0]        clr_inv;
		logic                      dev_clr_en;
	} blk_cfg_type;

	typedef struct packed {
		logic [NUM_CLK-1:0] dedicated_clk; // clock pins
		logic [NUM_CLK-1:0] global_sig;    // global signals, clock and clear
		logic [NUM_CLK-1:0] clk_local;     // clock from local lines
		logic [NUM_CLK-1:0] clk_en;        // paired clock enables
		logic [NUM_CLR-1:0] clr_local;     // clear from local lines
	} ctrl_in_type;

endpackage : pterm_pkg
